// File: ocm_ctrl.sv
// ocm_ctrl: data-cache miss handling, write-back and write-through
// buffers, cache ram mode and index mode.
// assumes cpu and memory-controller ports are on ref_clk; config bits
// come from a control register on the same clock.
//
// Summary of operation
// - clean read miss fills line wraparound from requested longword, returns data, sets valid.
// - dirty read miss saves victim to write-back buffer, fills, clears dirty, drains later.
// - cacheable write looks up entry by address 13:5 and compares tag against 28:10.
// - copy-back write hit merges bytes by offset and size, then sets dirty.
// - write-through write hit merges bytes and also writes memory at same size.
// - copy-back write miss clean: store, fill remaining bytes wraparound, set valid and dirty.
// - write-through write miss goes only to memory; no line allocated or changed.
// - copy-back write miss dirty: victim to buffer, merge, fill, then drain victim.
// - write-back buffer holds one line plus address so refills go first.
// - a 64-bit write-through buffer frees the cpu once the store is captured.
// - single-way ram mode uses entries 128-255 and 384-511 as ram.
// - two-way compatible ram mode uses entries 256-511, shadowed every 8 KB.
// - double mode ram uses 256-511 of both ways, alternating 8 KB, shadow 16 KB.
// - ram window is 0x7C000000-0x7FFFFFFF with byte to quadword reads and writes.
// - instruction fetches to the ram window are refused.
// - single-way, index off: ram area alternates every 8 KB (address bit 13), repeating 16 KB.
// - single-way, index on: address bit 25 selects ram area.
// - cache index is address 13:5, or bit 25 with 12:5 in index mode.
// - no hardware coherency; software keeps cache and memory consistent.
// - P1 follows copy-back select; others follow write-through select or page attribute.
// - power-on reset clears valid and dirty; manual reset keeps them.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module ocm_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        manual_rst,
  input  wire logic        two_way_variant,
  input  wire logic        data_cache_enable,
  input  wire logic        cache_ram_enable,
  input  wire logic        data_cache_index_mode,
  input  wire logic        double_cache_mode,
  input  wire logic        p1_copyback_select,
  input  wire logic        writethrough_select,
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic        cpu_ifetch,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [28:0] cpu_paddr,
  input  wire logic [1:0]  cpu_size,
  input  wire logic [63:0] cpu_wdata,
  input  wire logic        cpu_cacheable,
  input  wire logic        cpu_p1,
  input  wire logic        cpu_xlat,
  input  wire logic        cpu_tlb_wt,
  output logic             cpu_ready,
  output logic             cpu_rvalid,
  output logic [63:0]      cpu_rdata,
  output logic             cpu_err,
  output logic             mem_req,
  output logic             mem_we,
  output logic [28:0]      mem_addr,
  output logic [1:0]       mem_size,
  output logic [63:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [63:0] mem_rdata
);

  ocm_pkg::ocm_regs_type r;
  ocm_pkg::ocm_regs_type n;

  // tags and data are never initialised by any reset
  logic [ocm_pkg::LINE_W-1:0] data_arr [0:ocm_pkg::NWAYS-1][0:ocm_pkg::ENTRIES-1];
  logic [ocm_pkg::TAG_W-1:0]  tag_arr  [0:ocm_pkg::NWAYS-1][0:ocm_pkg::ENTRIES-1];

  logic                       accept;
  logic                       arr_we;
  logic                       arr_way;
  logic [ocm_pkg::IDX_W-1:0]  arr_idx;
  logic [ocm_pkg::LINE_W-1:0] arr_line;
  logic                       tag_we;
  logic [ocm_pkg::TAG_W-1:0]  tag_val;

  logic                       cache_on;
  logic                       ram_sel;
  logic [ocm_pkg::IDX_W-1:0]  lk_idx;
  logic [ocm_pkg::IDX_W-1:0]  ram_idx;
  logic                       ram_way;
  logic                       hit0;
  logic                       hit1;
  logic                       hit;
  logic                       hway;
  logic                       vway;
  logic                       vdirty;
  logic                       cb;
  logic                       cache_acc;
  logic                       need_fill;
  logic                       wt_cap;
  logic [31:0]                st_mask;
  logic [ocm_pkg::ENT_W-1:0]  hit_ent;
  logic [ocm_pkg::ENT_W-1:0]  fill_ent;
  logic [2:0]                 lw;

  // byte enables within a line for an access of given size
  function automatic logic [31:0] byte_mask(input logic [4:0] off,
                                            input logic [1:0] sz);
    logic [31:0] m;
    m = 32'h0;
    case (sz)
      ocm_pkg::SZ_BYTE: m = 32'h1 << off;
      ocm_pkg::SZ_WORD: m = 32'h3 << {off[4:1], 1'b0};
      ocm_pkg::SZ_LONG: m = 32'hF << {off[4:2], 2'b00};
      default:          m = 32'hFF << {off[4:3], 3'b000};
    endcase
    return m;
  endfunction : byte_mask

  // replace masked bytes; data sits in its 64-bit bus lane
  function automatic logic [255:0] merge(input logic [255:0] line,
                                         input logic [63:0]  d,
                                         input logic [31:0]  m);
    logic [255:0] o;
    o = line;
    for (int i = 0; i < 32; i++) begin
      if (m[i]) begin
        o[i*8 +: 8] = d[(i%8)*8 +: 8];
      end
    end
    return o;
  endfunction : merge

  // aligned doubleword of a line
  function automatic logic [63:0] dword(input logic [255:0] line,
                                        input logic [1:0]   sel);
    return line[sel*64 +: 64];
  endfunction : dword

  // normal cache index; ram half is kept out of cache use
  function automatic logic [8:0] cache_index(input logic [31:0] a,
                                             input logic ix,
                                             input logic ram,
                                             input logic two);
    logic [8:0] x;
    x = ix ? {a[ocm_pkg::IX_BIT], a[12:5]}
           : a[ocm_pkg::IDX_MSB:ocm_pkg::IDX_LSB];
    if (ram && two) begin
      x[8] = 1'b0;
    end else if (ram) begin
      x[7] = 1'b0;
    end
    return x;
  endfunction : cache_index

  // lookup of the current cpu request
  assign cache_on  = data_cache_enable;
  assign ram_sel   = cache_on && cache_ram_enable &&
                     cpu_addr[31:26] == ocm_pkg::RAM_TOP;
  assign lk_idx    = cache_index(cpu_addr, data_cache_index_mode,
                                 ram_sel ? 1'b0 : cache_ram_enable,
                                 two_way_variant);
  // ram entry select: single-way 4 KB areas, two-way 8 KB areas
  assign ram_idx   = two_way_variant ? {1'b1, cpu_addr[12:5]}
                   : {(data_cache_index_mode ? cpu_addr[ocm_pkg::IX_BIT]
                      : cpu_addr[ocm_pkg::RAM_AREA_B]),
                      1'b1, cpu_addr[11:5]};
  assign ram_way   = two_way_variant && double_cache_mode &&
                     cpu_addr[ocm_pkg::RAM_AREA_B];
  assign hit0      = r.valid[{1'b0, lk_idx}] &&
                     tag_arr[0][lk_idx] == cpu_paddr[28:10];
  assign hit1      = two_way_variant && r.valid[{1'b1, lk_idx}] &&
                     tag_arr[1][lk_idx] == cpu_paddr[28:10];
  assign hit       = hit0 || hit1;
  assign hway      = !hit0;
  assign vway      = !two_way_variant ? 1'b0
                   : !r.valid[{1'b0, lk_idx}] ? 1'b0
                   : !r.valid[{1'b1, lk_idx}] ? 1'b1
                   : r.lru[lk_idx];
  assign vdirty    = r.valid[{vway, lk_idx}] && r.dirty[{vway, lk_idx}];
  assign cb        = cpu_p1 ? p1_copyback_select
                   : (cpu_xlat ? !cpu_tlb_wt : !writethrough_select);
  assign cache_acc = cpu_req && !ram_sel && cache_on && cpu_cacheable;
  assign need_fill = cache_acc && !hit && !(cpu_we && !cb);
  assign wt_cap    = cpu_req && cpu_we && !ram_sel && !(cache_acc && cb);
  assign st_mask   = byte_mask(cpu_addr[4:0], cpu_size);
  assign hit_ent   = {hway, lk_idx};
  assign fill_ent  = {r.way, r.idx};
  assign lw        = r.off[4:2] + r.beat;

  // next-state logic
  always_comb begin
    n        = r;
    accept   = 1'b0;
    arr_we   = 1'b0;
    arr_way  = 1'b0;
    arr_idx  = '0;
    arr_line = '0;
    tag_we   = 1'b0;
    tag_val  = '0;
    n.rvalid = 1'b0;
    n.err    = 1'b0;
    case (r.st)
      ocm_pkg::S_IDLE: begin
        if (cpu_req) begin
          if (cpu_ifetch && ram_sel) begin
            accept = 1'b1;
            n.err  = 1'b1;
          end else if (ram_sel) begin
            accept = 1'b1;
            if (cpu_we) begin
              arr_we   = 1'b1;
              arr_way  = ram_way;
              arr_idx  = ram_idx;
              arr_line = merge(data_arr[ram_way][ram_idx], cpu_wdata,
                               st_mask);
            end else begin
              n.rvalid = 1'b1;
              n.rdata  = dword(data_arr[ram_way][ram_idx], cpu_addr[4:3]);
            end
          end else if (wt_cap) begin
            // write-through store or uncached store
            if (!r.wt_valid) begin
              accept    = 1'b1;
              n.wt_valid = 1'b1;
              n.wt_addr  = cpu_paddr;
              n.wt_size  = cpu_size;
              n.wt_data  = cpu_wdata;
              if (cache_acc && hit) begin
                arr_we   = 1'b1;
                arr_way  = hway;
                arr_idx  = lk_idx;
                arr_line = merge(data_arr[hway][lk_idx], cpu_wdata,
                                 st_mask);
                n.lru[lk_idx] = !hway;
              end
            end
          end else if (cache_acc && hit) begin
            accept        = 1'b1;
            n.lru[lk_idx] = !hway;
            if (cpu_we) begin
              arr_we   = 1'b1;
              arr_way  = hway;
              arr_idx  = lk_idx;
              arr_line = merge(data_arr[hway][lk_idx], cpu_wdata,
                               st_mask);
              n.dirty[hit_ent] = 1'b1;
            end else begin
              n.rvalid = 1'b1;
              n.rdata  = dword(data_arr[hway][lk_idx], cpu_addr[4:3]);
            end
          end else if (!r.wt_valid && !(vdirty && r.wb_valid)) begin
            // miss: cacheable fill, or uncached read; stall above
            accept     = 1'b1;
            n.mem_req  = 1'b1;
            n.mem_we   = 1'b0;
            n.beat     = ocm_pkg::BEAT_FIRST;
            n.line_addr = cpu_paddr[28:5];
            n.off      = cpu_paddr[4:0];
            n.size     = cpu_size;
            n.we       = cpu_we;
            if (need_fill) begin
              n.st         = ocm_pkg::S_FILL;
              n.idx        = lk_idx;
              n.way        = vway;
              n.returned   = 1'b0;
              n.fill_dirty = cpu_we;
              n.store_mask = cpu_we ? st_mask : 32'h0;
              n.fill_line  = cpu_we ? merge('0, cpu_wdata, st_mask) : '0;
              n.mem_addr   = {cpu_paddr[28:2], 2'b00};
              n.mem_size   = ocm_pkg::SZ_LONG;
              if (vdirty) begin
                n.wb_valid = 1'b1;
                n.wb_addr  = {tag_arr[vway][lk_idx], lk_idx[4:0]};
                n.wb_data  = data_arr[vway][lk_idx];
              end
            end else begin
              n.st       = ocm_pkg::S_UNC;
              n.mem_addr = cpu_paddr;
              n.mem_size = cpu_size;
            end
          end
        end
        // background drains when the cpu is not being served
        if (!accept && r.wt_valid) begin
          n.st        = ocm_pkg::S_WT;
          n.mem_req   = 1'b1;
          n.mem_we    = 1'b1;
          n.mem_addr  = r.wt_addr;
          n.mem_size  = r.wt_size;
          n.mem_wdata = r.wt_data;
        end else if (!accept && r.wb_valid) begin
          n.st        = ocm_pkg::S_WB;
          n.beat      = ocm_pkg::BEAT_FIRST;
          n.mem_req   = 1'b1;
          n.mem_we    = 1'b1;
          n.mem_addr  = {r.wb_addr, 3'h0, 2'b00};
          n.mem_size  = ocm_pkg::SZ_LONG;
          n.mem_wdata = {2{r.wb_data[31:0]}};
        end
      end
      ocm_pkg::S_FILL: begin
        if (mem_ack) begin
          n.fill_line = merge(r.fill_line, mem_rdata,
                              (32'hF << {lw, 2'b00}) & ~r.store_mask);
          if (!r.we && !r.returned &&
              r.beat == ((r.size == ocm_pkg::SZ_QUAD) ? 3'h1 : 3'h0)) begin
            n.rvalid   = 1'b1;
            n.returned = 1'b1;
            n.rdata    = dword(n.fill_line, r.off[4:3]);
          end
          if (r.beat == ocm_pkg::BEAT_LAST) begin
            arr_we   = 1'b1;
            arr_way  = r.way;
            arr_idx  = r.idx;
            arr_line = n.fill_line;
            tag_we   = 1'b1;
            tag_val  = r.line_addr[23:5];
            n.valid[fill_ent] = 1'b1;
            n.dirty[fill_ent] = r.fill_dirty;
            n.lru[r.idx] = !r.way;
            n.st      = ocm_pkg::S_IDLE;
            n.mem_req = 1'b0;
          end else begin
            n.beat     = r.beat + 3'h1;
            n.mem_addr = {r.line_addr, lw + 3'h1, 2'b00};
          end
        end
      end
      ocm_pkg::S_WB: begin
        if (mem_ack) begin
          if (r.beat == ocm_pkg::BEAT_LAST) begin
            n.wb_valid = 1'b0;
            n.st       = ocm_pkg::S_IDLE;
            n.mem_req  = 1'b0;
          end else begin
            n.beat      = r.beat + 3'h1;
            n.mem_addr  = {r.wb_addr, r.beat + 3'h1, 2'b00};
            n.mem_wdata = {2{r.wb_data[(r.beat + 3'h1)*32 +: 32]}};
          end
        end
      end
      ocm_pkg::S_WT: begin
        if (mem_ack) begin
          n.wt_valid = 1'b0;
          n.st       = ocm_pkg::S_IDLE;
          n.mem_req  = 1'b0;
        end
      end
      ocm_pkg::S_UNC: begin
        if (mem_ack) begin
          n.rvalid  = 1'b1;
          n.rdata   = mem_rdata;
          n.st      = ocm_pkg::S_IDLE;
          n.mem_req = 1'b0;
        end
      end
      default: begin
        n.st = ocm_pkg::S_IDLE;
      end
    endcase
    // manual reset restarts control but keeps valid, dirty and lru
    if (manual_rst) begin
      n       = ocm_pkg::REGS_RST;
      n.valid = r.valid;
      n.dirty = r.dirty;
      n.lru   = r.lru;
      accept  = 1'b0;
      arr_we  = 1'b0;
      tag_we  = 1'b0;
    end
  end

  // state register; power-on reset clears valid and dirty
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= ocm_pkg::REGS_RST;
    end else begin
      r <= n;
    end
  end

  // tag and data arrays, no reset
  always_ff @(posedge ref_clk) begin
    if (arr_we) begin
      data_arr[arr_way][arr_idx] <= arr_line;
    end
    if (tag_we) begin
      tag_arr[arr_way][arr_idx] <= tag_val;
    end
  end

  // outputs; coherency with memory is left to software
  assign cpu_ready  = accept;
  assign cpu_rvalid = r.rvalid;
  assign cpu_rdata  = r.rdata;
  assign cpu_err    = r.err;
  assign mem_req    = r.mem_req;
  assign mem_we     = r.mem_we;
  assign mem_addr   = r.mem_addr;
  assign mem_size   = r.mem_size;
  assign mem_wdata  = r.mem_wdata;

  // checks
  default clocking cb_clk @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_ram_ifetch_err: assert property (
    (r.st == ocm_pkg::S_IDLE && cpu_req && cpu_ifetch && ram_sel &&
     !manual_rst) |=> (cpu_err && !mem_req))
    else $error("ifetch to ram window not refused");
  a_fill_wrap_order: assert property (
    (r.st == ocm_pkg::S_FILL && mem_ack && r.beat != ocm_pkg::BEAT_LAST &&
     !manual_rst) |=> mem_addr[4:2] == $past(mem_addr[4:2]) + 3'h1)
    else $error("fill not in wraparound order");
  a_fill_sets_valid: assert property (
    (r.st == ocm_pkg::S_FILL && mem_ack && r.beat == ocm_pkg::BEAT_LAST &&
     !manual_rst) |=> r.valid[$past(fill_ent)] && r.st == ocm_pkg::S_IDLE)
    else $error("fill end did not validate line");
  a_fill_dirty_flag: assert property (
    (r.st == ocm_pkg::S_FILL && mem_ack && r.beat == ocm_pkg::BEAT_LAST &&
     !manual_rst) |=> r.dirty[$past(fill_ent)] == $past(r.fill_dirty))
    else $error("dirty flag wrong after fill");
  a_victim_to_wb: assert property (
    (accept && need_fill && vdirty) |=>
    (r.wb_valid && r.st == ocm_pkg::S_FILL && !mem_we))
    else $error("dirty victim not buffered before fill");
  a_refill_first: assert property (
    r.st == ocm_pkg::S_FILL |-> !mem_we)
    else $error("write issued during refill");
  a_cb_hit_dirty: assert property (
    (accept && cache_acc && hit && cpu_we && cb) |=>
    r.dirty[$past(hit_ent)])
    else $error("copy-back hit left line clean");
  a_wt_miss_noalloc: assert property (
    (accept && cache_acc && !hit && cpu_we && !cb) |=>
    (r.valid == $past(r.valid) && r.wt_valid))
    else $error("write-through miss touched cache");
  a_wb_busy_stall: assert property (
    (r.st == ocm_pkg::S_IDLE && need_fill && vdirty && r.wb_valid) |->
    !cpu_ready)
    else $error("dirty miss taken while buffer full");
  a_ram_no_bus: assert property (
    (accept && ram_sel && !r.wt_valid && !r.wb_valid) |=>
    !mem_req ##1 (!mem_req || $past(accept)))
    else $error("ram window access used the bus");

  c_fill_done:   cover property (r.st == ocm_pkg::S_FILL && mem_ack &&
                                 r.beat == ocm_pkg::BEAT_LAST);
  c_dirty_evict: cover property (accept && need_fill && vdirty);
  c_ram_write:   cover property (accept && ram_sel && cpu_we);
  c_wt_drain:    cover property (r.st == ocm_pkg::S_WT && mem_ack);

endmodule : ocm_ctrl

// File: ocm_pkg.sv
// ocm_pkg: constants, state encodings and register layout for the
// data-cache miss / write-buffer / on-chip ram controller.
// assumes a single 250 MHz clock and a 29-bit physical address space.
package ocm_pkg;

  // geometry
  localparam int IDX_W      = 9;
  localparam int TAG_W      = 19;
  localparam int LINE_W     = 256;
  localparam int ENTRIES    = 512;
  localparam int NWAYS      = 2;
  localparam int ENT_W      = 10;

  // address field positions
  localparam int TAG_LSB    = 10;
  localparam int TAG_MSB    = 28;
  localparam int IDX_LSB    = 5;
  localparam int IDX_MSB    = 13;
  localparam int IX_BIT     = 25;
  localparam int RAM_AREA_B = 13;

  // cache ram window 0x7C000000..0x7FFFFFFF: top six address bits
  localparam logic [5:0] RAM_TOP = 6'h1F;

  // access sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] SZ_QUAD = 2'h3;

  // beats of a line transfer, in longwords
  localparam logic [2:0] BEAT_FIRST = 3'h0;
  localparam logic [2:0] BEAT_LAST  = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FILL = 3'b001,
    S_WB   = 3'b010,
    S_WT   = 3'b011,
    S_UNC  = 3'b100
  } ocm_fsm_type;

  typedef struct packed {
    ocm_fsm_type          st;
    logic [2:0]           beat;
    logic [23:0]          line_addr;
    logic [4:0]           off;
    logic [1:0]           size;
    logic                 we;
    logic [IDX_W-1:0]     idx;
    logic                 way;
    logic [31:0]          store_mask;
    logic [LINE_W-1:0]    fill_line;
    logic                 fill_dirty;
    logic                 returned;
    logic                 wb_valid;
    logic [23:0]          wb_addr;
    logic [LINE_W-1:0]    wb_data;
    logic                 wt_valid;
    logic [28:0]          wt_addr;
    logic [1:0]           wt_size;
    logic [63:0]          wt_data;
    logic                 mem_req;
    logic                 mem_we;
    logic [28:0]          mem_addr;
    logic [1:0]           mem_size;
    logic [63:0]          mem_wdata;
    logic                 rvalid;
    logic [63:0]          rdata;
    logic                 err;
    logic [1023:0]        valid;
    logic [1023:0]        dirty;
    logic [ENTRIES-1:0]   lru;
  } ocm_regs_type;

  localparam ocm_regs_type REGS_RST = '0;

endpackage : ocm_pkg

// File: ocm_mem_model.sv
// ocm_mem_model: memory-bus partner for the data-cache controller.
// assumes one ref_clk domain; each held request gets one ack pulse.
`timescale 1ns/1ns
module ocm_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [28:0] mem_addr,
  output logic             mem_ack,
  output logic [63:0]      mem_rdata
);
  logic [1:0]  wait_cnt;
  logic [63:0] beat_data;
  // each 32-bit lane carries the address of the longword in that lane
  assign beat_data = {3'h5, mem_addr[28:3], 3'h4, 3'h5, mem_addr[28:3], 3'h0};
  // between acks the bus shows the inverse, so stale data cannot pass
  assign mem_rdata = mem_ack ? beat_data : ~beat_data;
  // ack after one cycle, or after three more when slow
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack  <= 1'b0;
      wait_cnt <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        if (!slow || wait_cnt == 2'h3) begin
          mem_ack  <= 1'b1;
          wait_cnt <= 2'h0;
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule : ocm_mem_model

// File: test_operand_cache_miss_ram_ctrl.sv
// test_operand_cache_miss_ram_ctrl: self-checking bench for ocm_ctrl.
// assumes ocm_mem_model on the memory port and one 250 MHz clock.
`timescale 1ns/1ns
module test_operand_cache_miss_ram_ctrl;
  logic ref_clk = 1'b0, sys_rst = 1'b1, manual_rst = 1'b0, slow = 1'b0;
  logic two_way_variant = 1'b0, data_cache_enable = 1'b1;
  logic cache_ram_enable = 1'b0, data_cache_index_mode = 1'b0;
  logic double_cache_mode = 1'b0, p1_copyback_select = 1'b1;
  logic writethrough_select = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0;
  logic cpu_ifetch = 1'b0, cpu_cacheable = 1'b1, cpu_p1 = 1'b1;
  logic cpu_xlat = 1'b0, cpu_tlb_wt = 1'b0, er;
  logic [31:0] cpu_addr = 32'h0;
  logic [28:0] cpu_paddr = 29'h0, mem_addr;
  logic [1:0]  cpu_size = 2'h0, mem_size;
  logic [63:0] cpu_wdata = 64'h0, cpu_rdata, mem_wdata, mem_rdata, rd;
  logic        cpu_ready, cpu_rvalid, cpu_err, mem_req, mem_we, mem_ack;
  logic [28:0] q_addr[$];
  logic [63:0] q_data[$];
  logic [2:0]  q_ws[$];
  int          err_total = 0, total_checks = 0, b;

  always #2 ref_clk = ~ref_clk;

  ocm_ctrl ocm_ctrl_inst (.ref_clk, .sys_rst, .manual_rst, .two_way_variant,
    .data_cache_enable, .cache_ram_enable, .data_cache_index_mode,
    .double_cache_mode, .p1_copyback_select, .writethrough_select, .cpu_req,
    .cpu_we, .cpu_ifetch, .cpu_addr, .cpu_paddr, .cpu_size, .cpu_wdata,
    .cpu_cacheable, .cpu_p1, .cpu_xlat, .cpu_tlb_wt, .cpu_ready, .cpu_rvalid,
    .cpu_rdata, .cpu_err, .mem_req, .mem_we, .mem_addr, .mem_size,
    .mem_wdata, .mem_ack, .mem_rdata);
  ocm_mem_model ocm_mem_model_inst (.ref_clk, .sys_rst, .slow, .mem_req,
    .mem_addr, .mem_ack, .mem_rdata);

  // log of completed memory beats
  always @(posedge ref_clk) begin
    if (mem_req === 1'b1 && mem_ack === 1'b1) begin
      q_addr.push_back(mem_addr);
      q_data.push_back(mem_wdata);
      q_ws.push_back({mem_we, mem_size});
    end
  end

  function automatic logic [31:0] mword(input logic [28:0] a);
    return {3'h5, a[28:2], 2'h0};
  endfunction : mword

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one cpu request held until taken; reads wait for their answer
  task automatic acc(input logic we, input logic [31:0] a,
                     input logic [1:0] sz, input logic [63:0] d,
                     input logic fetch);
    int n;
    n = 0;
    @(posedge ref_clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_paddr <= a[28:0];
    cpu_size <= sz;
    cpu_wdata <= d;
    cpu_ifetch <= fetch;
    @(negedge ref_clk);
    while (cpu_ready !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 400) err_total++;
    @(posedge ref_clk);
    cpu_req <= 1'b0;
    rd = 'x;
    if (!we) begin
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (cpu_rvalid !== 1'b1 && cpu_err !== 1'b1 && n < 400);
      if (n >= 400) err_total++;
      rd = cpu_rdata;
      er = cpu_err;
    end
  endtask : acc

  // waits until the memory port has been idle for eight cycles
  task automatic quiet;
    int k, n;
    k = 0;
    n = 0;
    while (k < 8 && n < 300) begin
      @(negedge ref_clk);
      n++;
      k = (mem_req === 1'b0) ? k + 1 : 0;
    end
    if (n >= 300) err_total++;
  endtask : quiet

  task automatic fill_chk(input logic [28:0] pa, input int s);
    logic [2:0] lw;
    for (int k = 0; k < 8; k++) begin
      lw = pa[4:2] + k[2:0];
      chk({34'h0, q_ws[s+k][2], q_addr[s+k]}, {35'h0, pa[28:5], lw, 2'h0});
    end
  endtask : fill_chk

  task automatic t_read_miss;
    b = q_addr.size();
    slow <= 1'b1;
    acc(1'b0, 32'h8001_2034, ocm_pkg::SZ_LONG, 64'h0, 1'b0);
    chk(rd[63:32], mword(29'h12034));
    quiet();
    fill_chk(29'h12034, b);
    slow <= 1'b0;
    acc(1'b0, 32'h8001_2030, ocm_pkg::SZ_QUAD, 64'h0, 1'b0);
    chk(rd, {mword(29'h12034), mword(29'h12030)});
    chk(q_addr.size(), b + 8);
    $display("test read_miss done");
  endtask : t_read_miss

  task automatic t_dirty_evict;
    b = q_addr.size();
    acc(1'b1, 32'h8001_2038, ocm_pkg::SZ_LONG, 64'hCAFE_F00D, 1'b0);
    acc(1'b0, 32'h8001_6038, ocm_pkg::SZ_LONG, 64'h0, 1'b0);
    chk(rd[31:0], mword(29'h16038));
    quiet();
    fill_chk(29'h16038, b);
    for (int k = 0; k < 8; k++) begin
      chk({q_ws[b+8+k][2], q_addr[b+8+k], q_data[b+8+k][31:0]},
          {1'b1, 24'h901, k[2:0], 2'h0, (k == 6) ? 32'hCAFE_F00D
          : mword({24'h901, k[2:0], 2'h0})});
    end
    chk(q_addr.size(), b + 16);
    $display("test dirty_evict done");
  endtask : t_dirty_evict

  task automatic t_write_through;
    writethrough_select <= 1'b1;
    cpu_p1 <= 1'b0;
    b = q_addr.size();
    acc(1'b1, 32'h0002_0006, ocm_pkg::SZ_WORD, 64'hBEEF << 48, 1'b0);
    quiet();
    chk({q_ws[b], q_addr[b], q_data[b][63:48]},
        {1'b1, ocm_pkg::SZ_WORD, 29'h20006, 16'hBEEF});
    acc(1'b0, 32'h0002_0004, ocm_pkg::SZ_LONG, 64'h0, 1'b0);
    quiet();
    fill_chk(29'h20004, b + 1);
    acc(1'b1, 32'h0001_6030, ocm_pkg::SZ_LONG, 64'h1234_5678, 1'b0);
    acc(1'b0, 32'h0001_6030, ocm_pkg::SZ_LONG, 64'h0, 1'b0);
    chk(rd[31:0], 32'h1234_5678);
    quiet();
    chk({q_ws[b+9], q_addr[b+9], q_data[b+9][31:0]},
        {1'b1, ocm_pkg::SZ_LONG, 29'h16030, 32'h1234_5678});
    chk(q_addr.size(), b + 10);
    writethrough_select <= 1'b0;
    cpu_p1 <= 1'b1;
    $display("test write_through done");
  endtask : t_write_through

  task automatic t_ram_mode;
    b = q_addr.size();
    cache_ram_enable <= 1'b1;
    acc(1'b1, 32'h7C00_1008, ocm_pkg::SZ_QUAD, 64'h0123_4567_89AB_CDEF, 1'b0);
    acc(1'b0, 32'h7C00_5008, ocm_pkg::SZ_QUAD, 64'h0, 1'b0);
    chk(rd, 64'h0123_4567_89AB_CDEF);
    acc(1'b0, 32'h7C00_0000, ocm_pkg::SZ_LONG, 64'h0, 1'b1);
    chk(er, 1'b1);
    chk(q_addr.size(), b);
    cache_ram_enable <= 1'b0;
    $display("test ram_mode done");
  endtask : t_ram_mode

  task automatic t_resets;
    b = q_addr.size();
    @(posedge ref_clk);
    manual_rst <= 1'b1;
    @(posedge ref_clk);
    manual_rst <= 1'b0;
    acc(1'b0, 32'h8001_6030, ocm_pkg::SZ_LONG, 64'h0, 1'b0);
    chk(q_addr.size(), b);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // copy-back store miss on a line cleared by power-on reset
    acc(1'b1, 32'h8001_6030, ocm_pkg::SZ_LONG, 64'hA5A5_5A5A, 1'b0);
    quiet();
    fill_chk(29'h16030, b);
    acc(1'b0, 32'h8001_6030, ocm_pkg::SZ_LONG, 64'h0, 1'b0);
    chk(rd[31:0], 32'hA5A5_5A5A);
    $display("test resets done");
  endtask : t_resets

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_read_miss();
    t_dirty_evict();
    t_write_through();
    t_ram_mode();
    t_resets();
    report_and_stop();
  end

  // watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
endmodule : test_operand_cache_miss_ram_ctrl
